// [include/cma_pkg.sv]
// package: sizes, map, modes and decode helpers of the macrocell array
package cma_pkg;
  localparam int N_DED      = 9;   // dedicated logic inputs
  localparam int N_MC       = 8;   // input/output macrocells
  localparam int CKP_COL    = 9;   // array column of the clock-or-input pin
  localparam int FB_COL     = 10;  // first feedback column
  localparam int ARR_W      = 18;  // 9 inputs, 1 clock pin, 8 feedbacks
  localparam int PT_PER_MC  = 9;   // 8 logic terms plus 1 enable term
  localparam int N_LOGIC_PT = 8;
  localparam int OE_PT_IDX  = 8;
  localparam int N_PT       = 72;
  localparam int ALT_OE_IDX = 8;   // input usable as a shared enable
  localparam int MODE_W     = 2;
  localparam int CFG_W      = 16;  // two bits per macrocell
  localparam int ADDR_W     = 8;
  localparam int DATA_W     = 32;
  localparam int PT_IDX_W   = 7;
  localparam logic [ADDR_W-1:0] FUSE_WORDS = 8'h90;
  localparam logic [ADDR_W-1:0] ADDR_MODE  = 8'h90;
  localparam logic [ADDR_W-1:0] ADDR_STAT  = 8'h91;
  localparam logic [ADDR_W-1:0] ADDR_PINS  = 8'h92;
  localparam logic [CFG_W-1:0]  MODE_RST   = 16'h0000;
  localparam logic [ARR_W-1:0]  MASK_RST   = 18'h00000;

  typedef enum logic [1:0] {
    CMA_MODE_INPUT  = 2'b00,
    CMA_MODE_COMB   = 2'b01,
    CMA_MODE_REG    = 2'b10,
    CMA_MODE_BURIED = 2'b11
  } cma_mode_e;

  typedef logic [ARR_W-1:0] cma_row_t;
  typedef cma_row_t [PT_PER_MC-1:0] cma_pts_t;

  // macrocell holds a register (pin-driving or buried)
  function automatic logic cma_is_reg(input logic [MODE_W-1:0] m);
    return (m == CMA_MODE_REG) || (m == CMA_MODE_BURIED);
  endfunction
endpackage

// [rtl/cma_sync.sv]
// three-stage pin synchroniser with agreement filter and rise pulse
`timescale 1ns/1ps
`default_nettype none
module cma_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o,
  output logic      [W-1:0] rise_o
);
  logic [W-1:0] s1_q, s2_q, s3_q, q_q, rise_q;
  logic [W-1:0] q_d, rise_d;

  // a bit moves only once stages two and three agree
  always_comb begin
    q_d    = (s3_q & ~(s2_q ^ s3_q)) | (q_q & (s2_q ^ s3_q));
    rise_d = q_d & ~q_q;
  end

  // s1 feeds s2 alone, so metastability never reaches logic
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_q   <= '0;
      s2_q   <= '0;
      s3_q   <= '0;
      q_q    <= '0;
      rise_q <= '0;
    end else begin
      s1_q   <= async_i;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      q_q    <= q_d;
      rise_q <= rise_d;
    end
  end

  assign sync_o = q_q;
  assign rise_o = rise_q;
endmodule // cma_sync
`default_nettype wire

// [rtl/cma_macrocell.sv]
// one macrocell: nine product terms, register, feedback and pin driver
`timescale 1ns/1ps
`default_nettype none
module cma_macrocell
  import cma_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic [ARR_W-1:0]     arr_i,
  input  wire cma_pts_t             tmask_i,
  input  wire cma_pts_t             cmask_i,
  input  wire logic [MODE_W-1:0]    mode_i,
  input  wire logic                 clk_en_i,
  input  wire logic                 pin_f_i,
  output logic                      fb_o,
  output logic                      reg_o,
  output logic                      pin_o,
  output logic                      pin_oe_o
);
  logic [PT_PER_MC-1:0] pt_w;
  logic sum_w, oe_pt_w, drive_w, reg_mode_w;
  logic reg_q, reg_d, pin_q, pin_d, oe_q, oe_d;

  // unprogrammed term (no literal) reads false, like an erased cell
  function automatic logic pt_eval(input cma_row_t a, input cma_row_t t,
                                   input cma_row_t c);
    if ((t | c) == '0)
      return 1'b0;
    return (&(a | ~t)) & (&(~a | ~c));
  endfunction

  // product terms
  for (genvar p = 0; p < PT_PER_MC; p++) begin : g_pt
    assign pt_w[p] = pt_eval(arr_i, tmask_i[p], cmask_i[p]);
  end

  assign sum_w      = |pt_w[N_LOGIC_PT-1:0];
  assign oe_pt_w    = pt_w[OE_PT_IDX];
  assign reg_mode_w = cma_is_reg(mode_i);
  assign drive_w    = (mode_i == CMA_MODE_COMB) || (mode_i == CMA_MODE_REG);

  // next register and pin values
  always_comb begin
    reg_d = reg_q;
    if (reg_mode_w && clk_en_i)
      reg_d = sum_w;
    oe_d  = drive_w & oe_pt_w;
    pin_d = (mode_i == CMA_MODE_REG) ? reg_q : sum_w;
  end

  // power-up clear: register low before any clock pin edge
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_q <= 1'b0;
      pin_q <= 1'b0;
      oe_q  <= 1'b0;
    end else begin
      reg_q <= reg_d;
      pin_q <= pin_d;
      oe_q  <= oe_d;
    end
  end

  // any register, buried or pin-driving, feeds back; otherwise the pin level comes back
  assign fb_o     = reg_mode_w ? reg_q : pin_f_i;
  assign reg_o    = reg_q;
  assign pin_o    = pin_q;
  assign pin_oe_o = oe_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_capture;
    reg_mode_w && clk_en_i;
  endsequence
  sequence s_shown;
    (mode_i != CMA_MODE_REG) || (pin_q == $past(reg_q));
  endsequence

  chk_reg_capture: assert property (
    s_capture |=> (reg_q == $past(sum_w)) ##1 s_shown)
    else $error("register missed its clock-pin capture");
  chk_reg_hold: assert property (
    !clk_en_i |=> $stable(reg_q))
    else $error("register changed without a clock-pin edge");
  chk_oe_off: assert property (
    !oe_pt_w |=> !oe_q)
    else $error("pin driven while enable term false");
  chk_buried_quiet: assert property (
    (mode_i == CMA_MODE_BURIED) |=> !oe_q)
    else $error("buried register drives its pin");
  chk_reg_own_oe: assert property (
    (mode_i == CMA_MODE_REG) && oe_pt_w |=> oe_q)
    else $error("registered cell ignored its enable term");
  chk_comb_sum: assert property (
    (mode_i == CMA_MODE_COMB) |=> pin_q == $past(|pt_w[7:0]))
    else $error("combinational pin not the sum of eight terms");
  // reset itself is the antecedent, so the default disable must not apply
  chk_powerup_low: assert property (
    @(posedge clk) disable iff (1'b0) !rst_n |=> !reg_q && !oe_q)
    else $error("register not low after power-up");
endmodule // cma_macrocell
`default_nettype wire

// [rtl/cma_array.sv]
// top of the macrocell array: configuration store, bus port, array wiring
//
// Functional notes
// - two mode bits per macrocell, sixteen in all, each cell independent
// - every macrocell register reads zero from power-up
// - nine dedicated inputs, one clock-or-input pin, eight macrocells
// - clock pin reaches the array only while no cell is registered
// - the shared-enable input stays a logic input in every mode
// - eight logic terms summed per cell, ninth term drives its enable
// - identical enable terms from one input give a shared enable
// - registered and combinational cells mix freely
// - any cell can be a buried register feeding the array
// - registered cells keep their own enable term
//
// Decided for this implementation: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module cma_array (
  input  wire logic                         CLK_SYS,
  input  wire logic                         RST_N,
  input  wire logic [cma_pkg::ADDR_W-1:0]   ADDR,
  input  wire logic [cma_pkg::DATA_W-1:0]   WDATA,
  input  wire logic                         WR,
  input  wire logic                         RD,
  output logic      [cma_pkg::DATA_W-1:0]   RDATA,
  input  wire logic [cma_pkg::N_DED-1:0]    IN_PINS,
  input  wire logic                         CLOCK_OR_INPUT_PIN,
  input  wire logic [cma_pkg::N_MC-1:0]     IO_PIN_I,
  output logic      [cma_pkg::N_MC-1:0]     IO_PIN_O,
  output logic      [cma_pkg::N_MC-1:0]     IO_PIN_OE
);
  import cma_pkg::*;

  // configuration state: true and complement literal masks per term
  logic [N_PT-1:0][ARR_W-1:0] tmask_q, tmask_d;
  logic [N_PT-1:0][ARR_W-1:0] cmask_q, cmask_d;
  logic [CFG_W-1:0]           mode_q, mode_d;
  logic [DATA_W-1:0]          rdata_q, rdata_d;

  // synchronised pins and array wiring
  logic [ARR_W-1:0]  pins_f, pins_rise, arr_w;
  logic [N_DED-1:0]  in_f;
  logic              ckp_f, clk_en, any_reg;
  logic [N_MC-1:0]   io_f, fb_w, reg_w, reg_cell;

  // fuse words sit below the mode register
  function automatic logic is_fuse(input logic [ADDR_W-1:0] a);
    return a < FUSE_WORDS;
  endfunction

  // even word: true mask, odd word: complement mask
  function automatic logic [PT_IDX_W-1:0] fuse_pt(
    input logic [ADDR_W-1:0] a);
    return a[ADDR_W-1:1];
  endfunction

  // configuration writes; strobes never overlap, so no ordering hazard
  always_comb begin
    tmask_d = tmask_q;
    cmask_d = cmask_q;
    mode_d  = mode_q;
    if (WR) begin
      if (is_fuse(ADDR)) begin
        if (ADDR[0])
          cmask_d[fuse_pt(ADDR)] = WDATA[ARR_W-1:0];
        else
          tmask_d[fuse_pt(ADDR)] = WDATA[ARR_W-1:0];
      end else if (ADDR == ADDR_MODE) begin
        mode_d = WDATA[CFG_W-1:0];
      end
    end
  end

  // read mux; data valid only in the cycle after the strobe
  always_comb begin
    rdata_d = '0;
    if (RD) begin
      if (is_fuse(ADDR)) begin
        if (ADDR[0])
          rdata_d[ARR_W-1:0] = cmask_q[fuse_pt(ADDR)];
        else
          rdata_d[ARR_W-1:0] = tmask_q[fuse_pt(ADDR)];
      end else begin
        case (ADDR)
          ADDR_MODE: rdata_d[CFG_W-1:0] = mode_q;
          ADDR_STAT: rdata_d[CFG_W-1:0] = {IO_PIN_OE, reg_w};
          ADDR_PINS: rdata_d[ARR_W-1:0] = {io_f, ckp_f, in_f};
          default:   rdata_d = '0; // unmapped reads as zero
        endcase
      end
    end
  end

  // erased array after reset: no term ever true, no pin driven
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      tmask_q <= {N_PT{MASK_RST}};
      cmask_q <= {N_PT{MASK_RST}};
      mode_q  <= MODE_RST;
      rdata_q <= '0;
    end else begin
      tmask_q <= tmask_d;
      cmask_q <= cmask_d;
      mode_q  <= mode_d;
      rdata_q <= rdata_d;
    end
  end

  assign RDATA = rdata_q;

  // all pin inputs cross into the system clock the same way
  cma_sync #(
    .W (ARR_W)
  ) u_sync (
    .clk     (CLK_SYS),
    .rst_n   (RST_N),
    .async_i ({IO_PIN_I, CLOCK_OR_INPUT_PIN, IN_PINS}),
    .sync_o  (pins_f),
    .rise_o  (pins_rise)
  );

  assign in_f   = pins_f[N_DED-1:0];
  assign ckp_f  = pins_f[CKP_COL];
  assign io_f   = pins_f[ARR_W-1:FB_COL];
  // clock rate is limited to a few system cycles per half period
  assign clk_en = pins_rise[CKP_COL];

  // per-cell register decode, shared by every cell
  for (genvar m = 0; m < N_MC; m++) begin : g_reg
    assign reg_cell[m] = cma_is_reg(mode_q[m*MODE_W +: MODE_W]);
  end
  assign any_reg = |reg_cell;

  // clock pin is masked out of the array once any register exists;
  // every dedicated input (the shared-enable one too) always passes
  assign arr_w = {fb_w, ckp_f & ~any_reg, in_f};

  // each cell gets its own nine terms and its own mode field,
  // so a shared enable is just eight identical enable-term masks
  for (genvar m = 0; m < N_MC; m++) begin : g_mc
    cma_macrocell u_mc (
      .clk      (CLK_SYS),
      .rst_n    (RST_N),
      .arr_i    (arr_w),
      .tmask_i  (tmask_q[m*PT_PER_MC +: PT_PER_MC]),
      .cmask_i  (cmask_q[m*PT_PER_MC +: PT_PER_MC]),
      .mode_i   (mode_q[m*MODE_W +: MODE_W]),
      .clk_en_i (clk_en),
      .pin_f_i  (io_f[m]),
      .fb_o     (fb_w[m]),
      .reg_o    (reg_w[m]),
      .pin_o    (IO_PIN_O[m]),
      .pin_oe_o (IO_PIN_OE[m])
    );
  end

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);

  sequence s_mode_write;
    WR && (ADDR == ADDR_MODE);
  endsequence

  chk_mode_store: assert property (
    s_mode_write |=> mode_q == $past(WDATA[CFG_W-1:0]))
    else $error("mode bits not taken from write");
  chk_mode_keep: assert property (
    !(WR && ADDR == ADDR_MODE) |=> $stable(mode_q))
    else $error("mode bits changed without a write");
  chk_input_path: assert property (
    $stable(IN_PINS)[*5] |-> in_f == IN_PINS)
    else $error("dedicated inputs not reaching the array");
  chk_clkpin_masked: assert property (
    any_reg |-> !arr_w[CKP_COL])
    else $error("clock pin fed array while registers in use");
  chk_clkpin_input: assert property (
    !any_reg |-> arr_w[CKP_COL] == ckp_f)
    else $error("clock pin lost as input with no registers");
  chk_alt_oe_input: assert property (
    any_reg |-> arr_w[ALT_OE_IDX] == in_f[ALT_OE_IDX])
    else $error("shared-enable input lost in registered use");
  chk_read_once: assert property (
    !RD |=> RDATA == '0)
    else $error("read data stands outside its cycle");
  chk_fb_reg: assert property (
    reg_cell[0] |-> fb_w[0] == reg_w[0])
    else $error("buried feedback not from register");
endmodule // cma_array
`default_nettype wire

// [bench/cma_board.sv]
// board model: resolves each macrocell pin from device and board
`timescale 1ns/1ps
`default_nettype none
module cma_board (
  input  wire logic [7:0] dev_val,
  input  wire logic [7:0] dev_en,
  input  wire logic [7:0] board_val,
  output logic      [7:0] pin_level
);
  // board drives a pin only while the device lets it float
  always_comb begin
    for (int c = 0; c < 8; c++) begin
      pin_level[c] = dev_en[c] ? dev_val[c] : board_val[c];
    end
  end
endmodule // cma_board
`default_nettype wire

// [bench/cma_array_tb_top.sv]
// self-checking bench of the macrocell array with a board model
`timescale 1ns/1ps
`default_nettype none
module cma_array_tb_top;
  import cma_pkg::*;
  logic              clk_sys;
  logic              rst_n;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic              wr;
  logic              rd;
  logic [DATA_W-1:0] rdata;
  logic [N_DED-1:0]  in_pins;
  logic              ckp;
  logic [N_MC-1:0]   pin_lvl;
  logic [N_MC-1:0]   pin_val;
  logic [N_MC-1:0]   pin_en;
  logic [N_MC-1:0]   board_val;
  logic [15:0]       mode;
  logic [7:0]        regs;
  logic [31:0]       d;
  int                miscompares;
  int                num_checks;
  logic [15:0]       mode_tab [4] = '{16'h5555, 16'h75aa, 16'haaaa, 16'h0};

  cma_array u_dut (.CLK_SYS(clk_sys), .RST_N(rst_n), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .IN_PINS(in_pins),
    .CLOCK_OR_INPUT_PIN(ckp), .IO_PIN_I(pin_lvl), .IO_PIN_O(pin_val),
    .IO_PIN_OE(pin_en));
  cma_board u_board (.dev_val(pin_val), .dev_en(pin_en),
    .board_val(board_val), .pin_level(pin_lvl));

  // 20 MHz system clock
  always #25 clk_sys = ~clk_sys;

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic bus_rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_sys);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1 v = rdata;
  endtask

  // expected {enables, driven values}; floating pins compare as 0
  function automatic logic [15:0] exp_pins(input logic [15:0] m,
    input logic [8:0] in, input logic ck, input logic [7:0] r);
    logic [7:0] o;
    logic [7:0] oe;
    logic       anyreg;
    anyreg = 1'b0;
    for (int c = 0; c < 8; c++) anyreg |= m[2*c+1];
    for (int c = 0; c < 8; c++) begin
      oe[c] = in[8] & (m[2*c+:2] == 2'b01 || m[2*c+:2] == 2'b10);
      o[c] = m[2*c+1] ? r[c] : (in[c] | (c == 7 && ck && !anyreg));
    end
    return {oe, o & oe};
  endfunction

  task automatic check_all();
    logic [15:0] e;
    logic [31:0] v;
    logic [7:0]  rm;
    logic [7:0]  lvl;
    e = exp_pins(mode, in_pins, ckp, regs);
    for (int c = 0; c < 8; c++) rm[c] = mode[2*c+1];
    chk("pins", {16'h0, pin_en, pin_val & pin_en}, {16'h0, e});
    bus_rd(ADDR_STAT, v);
    chk("status", v & {16'h0, 8'hff, rm}, {16'h0, e[15:8], regs & rm});
    lvl = e[7:0] | (board_val & ~e[15:8]);
    bus_rd(ADDR_PINS, v);
    chk("pin levels", v & 32'h3ffff, {14'h0, lvl, ckp, in_pins});
  endtask

  // watchdog: the whole run needs just under six hundred cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    miscompares++;
    print_verdict();
  end

  initial begin
    clk_sys = 1'b0;
    rst_n = 1'b0;
    addr = '0;
    wdata = '0;
    wr = 1'b0;
    rd = 1'b0;
    in_pins = '0;
    ckp = 1'b0;
    board_val = '0;
    mode = '0;
    regs = '0;
    miscompares = 0;
    num_checks = 0;
    void'($urandom(32'h7e88f728));
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    bus_rd(ADDR_MODE, d);
    chk("mode reset", d, 32'h0);
    bus_rd(ADDR_STAT, d);
    chk("status reset", d, 32'h0);
    bus_rd(8'hc5, d);
    chk("unmapped", d, 32'h0);
    // term 0 of cell c takes input c; every enable term takes input 8
    for (int c = 0; c < 8; c++) begin
      bus_wr(8'(18 * c), 32'(1) << c);
      bus_wr(8'(18 * c + 16), 32'h100);
    end
    bus_wr(8'(18 * 7 + 2), 32'h200);
    for (int k = 0; k < 4; k++) begin
      mode = (k == 3) ? 16'($urandom) : mode_tab[k];
      bus_wr(ADDR_MODE, {16'($urandom), mode});
      bus_rd(ADDR_MODE, d);
      chk("mode", d & 32'hffff, {16'h0, mode});
      for (int it = 0; it < 4; it++) begin
        in_pins <= (it == 0) ? 9'h1ff : (it == 1) ? 9'h0ff : 9'($urandom);
        board_val <= 8'($urandom);
        repeat (8) @(posedge clk_sys);
        ckp <= 1'b1;
        repeat (8) @(posedge clk_sys);
        regs = in_pins[7:0];
        check_all();
        ckp <= 1'b0;
        repeat (8) @(posedge clk_sys);
        check_all();
      end
    end
    print_verdict();
  end
endmodule // cma_array_tb_top
`default_nettype wire
